// ===== src/pib_regs.svh
`ifndef PIB_REGS_SVH
`define PIB_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses, low bits of HADDR)
// ****************************************************************
`define PIB_ADDR_BITS        12
`define PIB_OFS_ENABLE       12'h000
`define PIB_OFS_CONTROL      12'h004
`define PIB_OFS_FLAGS        12'h008

// ****************************************************************
// Field positions: sources shared by enable and flag registers, global and group in control
// ****************************************************************
`define PIB_BIT_RX           5
`define PIB_BIT_TX           4
`define PIB_BIT_COLLISION    1
`define PIB_BIT_SYNC         0
`define PIB_BIT_GLOBAL       7
`define PIB_BIT_GROUP        6
`define PIB_REG_MSB          7
`define PIB_PAD_ZERO         24'h00_0000

// ****************************************************************
// Reset values and bus constants
// ****************************************************************
`define PIB_ENABLE_RESET     4'h0
`define PIB_CONTROL_RESET    2'h0
`define PIB_FLAGS_RESET      4'h0
`define PIB_WORD_ZERO        32'h0000_0000
`define PIB_BYTE_ZERO        8'h00
`define PIB_RESP_OKAY        1'h0
`define PIB_HTRANS_ACTIVE    1

`endif

// ===== src/pib_pkg.sv
`include "pib_regs.svh"
package pib_pkg;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Four sources: 3 receive, 2 transmit, 1 collision, 0 sync event
    typedef logic [3:0] pib_src_type;

    // Bus slave state
    typedef enum logic [1:0]
    {
        PIB_ST_IDLE   = 2'b00,  // Ready, no read pending
        PIB_ST_RDWAIT = 2'b01   // One wait state while read data settles
    } pib_bus_state_type;

    // ****************************************************************
    // Layout helpers
    // ****************************************************************
    // Spread the four sources onto their register bit positions
    function automatic logic [7:0] pib_pack(input pib_src_type src);
        logic [7:0] v;
        v = `PIB_BYTE_ZERO;
        v[`PIB_BIT_RX]        = src[3];
        v[`PIB_BIT_TX]        = src[2];
        v[`PIB_BIT_COLLISION] = src[1];
        v[`PIB_BIT_SYNC]      = src[0];
        return v;
    endfunction : pib_pack

    // Gather the four sources from a register byte; other bits dropped
    function automatic pib_src_type pib_unpack(input logic [7:0] v);
        return {v[`PIB_BIT_RX], v[`PIB_BIT_TX], v[`PIB_BIT_COLLISION], v[`PIB_BIT_SYNC]};
    endfunction : pib_unpack

endpackage : pib_pkg

// ===== src/pib_gate_if.sv
`timescale 1ns/1ps
// ****************************************************************
// Link between register front end and the flag/gate unit
// ****************************************************************
interface pib_gate_if;
    import pib_pkg::*;
    pib_src_type enable;     // Per-source enable bits
    logic        group_en;   // Peripheral group enable
    logic        global_en;  // Global enable
    pib_src_type clear;      // One-cycle clear strobes for flags
    pib_src_type flags;      // Pending flags
    logic        request;    // Registered request toward the core

    modport ctrl (output enable, group_en, global_en, clear, input flags, request);
    modport gate (input enable, group_en, global_en, clear, output flags, request);
endinterface : pib_gate_if

// ===== src/pib_gate.sv
`timescale 1ns/1ps
`include "pib_regs.svh"
// ****************************************************************
// Flag capture and request gating
// ****************************************************************
module pib_gate
    import pib_pkg::*;
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  reset,
    // Peripheral event pulses, same clock
    input  wire pib_src_type events,
    // Front end link
    pib_gate_if.gate   link
);

    pib_src_type flags_r;     // Pending flags
    pib_src_type flags_nxt;
    logic        request_r;   // Request to the core
    logic        request_nxt;

    // Next flags and request; an event in the clear cycle survives
    always_comb
    begin
        flags_nxt   = (flags_r & ~link.clear) | events;
        // Each source passes through its own enable bit, then the group and global enables
        request_nxt = link.global_en & link.group_en
                    & (|(flags_r & link.enable));
    end

    // Register stage
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            flags_r   <= `PIB_FLAGS_RESET;
            request_r <= 1'b0;
        end
        else
        begin
            flags_r   <= flags_nxt;
            request_r <= request_nxt;
        end
    end

    assign link.flags   = flags_r;
    assign link.request = request_r;

endmodule : pib_gate

// ===== src/pib_top.sv
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "pib_regs.svh"
// ****************************************************************
// Fourth peripheral interrupt enable bank with AHB-Lite access
// ****************************************************************
// Map: enable bank, interrupt control, then pending flags, one word each
// Reads take one wait state, writes take none; the response is always OKAY
// No synchronisers: every input comes from logic on the core clock
module pib_top
    import pib_pkg::*;
(
    // Clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RESET,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Peripheral event pulses
    input  wire logic        SER2_RX_EVENT,
    input  wire logic        SER2_TX_EVENT,
    input  wire logic        SYNC2_COLLISION_EVENT,
    input  wire logic        SYNC2_EVENT,
    // Interrupt request to the core
    output logic             IRQ_TO_CORE
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    // Gate link
    pib_gate_if link ();                               // To the gate unit

    // Bus slave state
    pib_bus_state_type           state_r;              // Bus slave state
    pib_bus_state_type           state_nxt;
    logic                        wr_pend_r;            // Write data phase due
    logic                        wr_pend_nxt;
    logic [`PIB_ADDR_BITS-1:0]   addr_r;               // Latched address
    logic [`PIB_ADDR_BITS-1:0]   addr_nxt;
    logic [31:0]                 hrdata_r;             // Read data
    logic [31:0]                 hrdata_nxt;
    logic                        hready_r;             // Ready out
    logic                        hready_nxt;
    logic                        hresp_r;              // Response out, always OKAY
    logic                        hresp_nxt;
    // Register bank state
    pib_src_type                 enable_r;             // Enable bank
    pib_src_type                 enable_nxt;
    logic [1:0]                  control_r;            // {global, group}
    logic [1:0]                  control_nxt;
    // Strobes and decode
    pib_src_type                 clear;                // Flag clear strobes
    logic                        take;                 // Address phase taken

    // ****************************************************************
    // Register readback
    // ****************************************************************
    // Readback of one register; unmapped reads as zero
    function automatic logic [31:0] read_reg(input logic [`PIB_ADDR_BITS-1:0] a);
        logic [7:0] v;
        v = `PIB_BYTE_ZERO;
        case (a)
            // Enable bank: reserved positions come back as zero
            `PIB_OFS_ENABLE:  v = pib_pack(enable_r);
            // Control: only the global and group bits exist
            `PIB_OFS_CONTROL:
            begin
                v[`PIB_BIT_GLOBAL] = control_r[1];
                v[`PIB_BIT_GROUP]  = control_r[0];
            end
            // Pending flags, straight from the gate unit
            `PIB_OFS_FLAGS:   v = pib_pack(link.flags);
            // Holes in the map read as zero, never an error
            default:          v = `PIB_BYTE_ZERO;
        endcase
        // Only the low byte is implemented; the pad is constant zero
        return {`PIB_PAD_ZERO, v};
    endfunction : read_reg

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // Reads take one wait state so a write just before is seen
    always_comb
    begin
        // Taken only while the bus is ready and the transfer is real
        take        = HSEL & HREADY & HTRANS[`PIB_HTRANS_ACTIVE];
        // Defaults: hold state, keep ready high, answer OKAY
        state_nxt   = state_r;
        wr_pend_nxt = take & HWRITE;
        addr_nxt    = take ? HADDR[`PIB_ADDR_BITS-1:0] : addr_r;
        hrdata_nxt  = hrdata_r;
        hready_nxt  = 1'b1;
        hresp_nxt   = `PIB_RESP_OKAY;
        // Two states: idle, or one wait for read data
        case (state_r)
            PIB_ST_IDLE:
            begin
                // Writes never wait: the bank takes HWDATA one edge later
                // Read accepted: stall the data phase one cycle
                if (take && !HWRITE)
                begin
                    state_nxt  = PIB_ST_RDWAIT;
                    hready_nxt = 1'b0;
                end
            end
            PIB_ST_RDWAIT:
            begin
                // Sample the register now, release the bus
                // Sampling here, not at the address edge, lets a write just before show up
                hrdata_nxt = read_reg(addr_r);
                state_nxt  = PIB_ST_IDLE;
            end
            default:
            begin
                // Unused code: fall back to idle
                state_nxt = PIB_ST_IDLE;
            end
        endcase
    end

    // Bus slave registers; ready leaves reset high so the bus never hangs
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            // Idle, ready, nothing pending
            state_r   <= PIB_ST_IDLE;
            wr_pend_r <= 1'b0;
            addr_r    <= `PIB_OFS_ENABLE;
            hrdata_r  <= `PIB_WORD_ZERO;
            hready_r  <= 1'b1;
            hresp_r   <= `PIB_RESP_OKAY;
        end
        else
        begin
            state_r   <= state_nxt;
            wr_pend_r <= wr_pend_nxt;
            addr_r    <= addr_nxt;
            hrdata_r  <= hrdata_nxt;
            hready_r  <= hready_nxt;
            hresp_r   <= hresp_nxt;
        end
    end

    // ****************************************************************
    // Register bank
    // ****************************************************************
    // Writes land in the data phase; reserved bits are simply dropped
    always_comb
    begin
        // Defaults: hold the bank, no clear strobes
        enable_nxt  = enable_r;
        control_nxt = control_r;
        clear       = `PIB_FLAGS_RESET;
        if (wr_pend_r)
        begin
            case (addr_r)
                // Enable bank: only the four implemented bits are kept
                `PIB_OFS_ENABLE:  enable_nxt = pib_unpack(HWDATA[`PIB_REG_MSB:0]);
                // Control: global and group enables
                `PIB_OFS_CONTROL: control_nxt = {HWDATA[`PIB_BIT_GLOBAL], HWDATA[`PIB_BIT_GROUP]};
                // Write one to clear a flag
                `PIB_OFS_FLAGS:   clear = pib_unpack(HWDATA[`PIB_REG_MSB:0]);
                // Unmapped offset: write ignored
                default:          enable_nxt = enable_r;
            endcase
        end
    end

    // Every reset source returns the bank to zero
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            // Bank and control clear together, so no request follows a reset
            enable_r  <= `PIB_ENABLE_RESET;
            control_r <= `PIB_CONTROL_RESET;
        end
        else
        begin
            enable_r  <= enable_nxt;
            control_r <= control_nxt;
        end
    end

    // ****************************************************************
    // Gate unit
    // ****************************************************************
    // Feed the gate unit straight from the bank registers and the clear strobes
    // Group enable is control bit 0, global enable control bit 1
    assign link.enable    = enable_r;
    assign link.group_en  = control_r[0];
    assign link.global_en = control_r[1];
    assign link.clear     = clear;

    // Flags and the registered request live in the gate unit
    pib_gate u_gate
    (
        .clk    (CORE_CLK),
        .reset  (RESET),
        .events ({SER2_RX_EVENT, SER2_TX_EVENT, SYNC2_COLLISION_EVENT, SYNC2_EVENT}),
        .link   (link.gate)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every output leaves straight from a register
    assign HRDATA      = hrdata_r;
    assign HREADYOUT   = hready_r;
    assign HRESP       = hresp_r;
    assign IRQ_TO_CORE = link.request;

endmodule : pib_top

// ===== sim/pib_top_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// Bus timing and request gating, seen from the top pins
// ****************************************************************
module pib_top_assertions
(
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RESET,
    // Bus
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    // Events and request
    input wire logic        SER2_RX_EVENT,
    input wire logic        SER2_TX_EVENT,
    input wire logic        SYNC2_COLLISION_EVENT,
    input wire logic        SYNC2_EVENT,
    input wire logic        IRQ_TO_CORE
);
    logic       take;    // Address phase accepted
    logic [3:0] evt;     // Events in source order
    logic       wen_r;   // Write data phase pending
    logic [1:0] wsel_r;  // Target: 1 control, 0 enable
    logic [3:0] en_r;    // Shadow of the enable bits
    logic [1:0] ctl_r;   // Shadow of global and group enables
    assign take = HSEL && HREADY && HTRANS[1];
    assign evt  = {SER2_RX_EVENT, SER2_TX_EVENT, SYNC2_COLLISION_EVENT, SYNC2_EVENT};
    // Shadow follows writes so gating can be judged from pins alone
    always_ff @(posedge CORE_CLK or posedge RESET)
    begin
        if (RESET)
        begin
            wen_r  <= 1'b0;
            wsel_r <= 2'b00;
            en_r   <= 4'h0;
            ctl_r  <= 2'b00;
        end
        else
        begin
            wen_r <= take && HWRITE;
            if (take)
                wsel_r <= {HADDR[11:0] == 12'h004, HADDR[11:0] == 12'h000};
            if (wen_r && wsel_r[0])
                en_r <= {HWDATA[5], HWDATA[4], HWDATA[1], HWDATA[0]};
            if (wen_r && wsel_r[1])
                ctl_r <= HWDATA[7:6];
        end
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT) else $error("read wait wrong");
    a_write_fast: assert property (take && HWRITE |=> HREADYOUT) else $error("write stalled");
    a_ready_once: assert property (!HREADYOUT |=> HREADYOUT) else $error("ready low too long");
    a_upper_zero: assert property (HRDATA[31:8] == 24'h00_0000) else $error("upper read bits set");
    a_resp_okay: assert property (HRESP == 1'b0) else $error("response not okay");
    a_enable_read: assert property (take && !HWRITE && HADDR[11:0] == 12'h000 |=> ##2
        HRDATA[7:0] == {2'b00, en_r[3:2], 2'b00, en_r[1:0]}) else $error("enable readback wrong");
    a_irq_gated: assert property (IRQ_TO_CORE |-> $past(ctl_r) == 2'b11) else $error("request ungated");
    a_irq_enabled: assert property (IRQ_TO_CORE |-> $past(en_r) != 4'h0) else $error("request unenabled");
    a_irq_rises: assert property (|(evt & en_r) && ctl_r == 2'b11 |=> ##[0:1] IRQ_TO_CORE)
        else $error("request missing");
endmodule : pib_top_assertions

bind pib_top pib_top_assertions u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SER2_RX_EVENT(SER2_RX_EVENT), .SER2_TX_EVENT(SER2_TX_EVENT),
    .SYNC2_COLLISION_EVENT(SYNC2_COLLISION_EVENT), .SYNC2_EVENT(SYNC2_EVENT), .IRQ_TO_CORE(IRQ_TO_CORE));

// ===== sim/pib_periph_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Serial peripherals: one-cycle event pulses on request
// ****************************************************************
module pib_periph_model
    import pib_pkg::*;
(
    // Clock
    input wire logic        clk,
    // Requests, one bit a source
    input wire pib_src_type fire,
    // Event pulses
    output logic            rx_event,
    output logic            tx_event,
    output logic            collision_event,
    output logic            sync_event
);
    // Pulse whatever the requests say; lines rest low between events
    always_ff @(posedge clk)
    begin
        {rx_event, tx_event, collision_event, sync_event} <= fire;
    end
endmodule : pib_periph_model

// ===== sim/pib_top_tb.sv
`timescale 1ns/1ps
`include "pib_regs.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, a); end end
// ****************************************************************
// Self-checking bench
// ****************************************************************
module pib_top_tb;
    import pib_pkg::*;
    logic        clk, rst, hsel, hwrite, hreadyout, hresp, irq, rx, tx, col, syn;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    pib_src_type fire;        // Event requests to the peripheral model
    int          fail_count = 0;
    int          tests_run  = 0;
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    pib_top u_dut (.CORE_CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .SER2_RX_EVENT(rx), .SER2_TX_EVENT(tx), .SYNC2_COLLISION_EVENT(col),
        .SYNC2_EVENT(syn), .IRQ_TO_CORE(irq));
    pib_periph_model u_periph (.clk(clk), .fire(fire), .rx_event(rx), .tx_event(tx),
        .collision_event(col), .sync_event(syn));
    // One single transfer; waits on ready, the watchdog cuts a hang
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {20'h0_0000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic t_reset_values();
        bus(0, `PIB_OFS_ENABLE, 32'h0000_0000);
        `CHK("enable reset", 32'h0000_0000, rd)
        bus(0, `PIB_OFS_CONTROL, 32'h0000_0000);
        `CHK("control reset", 32'h0000_0000, rd)
    endtask : t_reset_values
    task automatic t_reserved();
        bus(1, `PIB_OFS_ENABLE, 32'hFFFF_FFFF);
        bus(0, `PIB_OFS_ENABLE, 32'h0000_0000);
        `CHK("enable readback", 32'h0000_0033, rd)
        bus(1, 12'h00C, 32'hFFFF_FFFF);
        bus(0, 12'h00C, 32'h0000_0000);
        `CHK("unmapped read", 32'h0000_0000, rd)
        bus(1, `PIB_OFS_ENABLE, 32'h0000_0000);
    endtask : t_reserved
    // Each source: flag sets while disabled, then enable and both gates
    task automatic t_gating();
        int pos;
        for (int i = 0; i < 4; i++)
        begin
            pos = (i < 2) ? i : i + 2;
            bus(1, `PIB_OFS_CONTROL, 32'h0000_00C0);
            bus(1, `PIB_OFS_FLAGS, 32'h0000_0033);
            @(posedge clk);
            fire <= 4'h1 << i;
            @(posedge clk);
            fire <= 4'h0;
            repeat (3) @(posedge clk);
            `CHK("request while disabled", 1'b0, irq)
            bus(0, `PIB_OFS_FLAGS, 32'h0000_0000);
            `CHK("flag set", 32'h0000_0001 << pos, rd)
            bus(1, `PIB_OFS_ENABLE, 32'h0000_0001 << pos);
            repeat (2) @(posedge clk);
            `CHK("request enabled", 1'b1, irq)
            bus(1, `PIB_OFS_CONTROL, 32'h0000_0080);
            repeat (2) @(posedge clk);
            `CHK("group off", 1'b0, irq)
            bus(1, `PIB_OFS_CONTROL, 32'h0000_0040);
            repeat (2) @(posedge clk);
            `CHK("global off", 1'b0, irq)
            bus(1, `PIB_OFS_ENABLE, 32'h0000_0000);
        end
    endtask : t_gating
    // Event while enabled raises the request, a clear drops it, global off holds it back
    task automatic t_event_enabled();
        bus(1, `PIB_OFS_CONTROL, 32'h0000_00C0);
        bus(1, `PIB_OFS_FLAGS, 32'h0000_0033);
        bus(1, `PIB_OFS_ENABLE, 32'h0000_0020);
        @(posedge clk);
        fire <= 4'h8;
        @(posedge clk);
        fire <= 4'h0;
        repeat (3) @(posedge clk);
        `CHK("request on event", 1'b1, irq)
        bus(1, `PIB_OFS_FLAGS, 32'h0000_0020);
        repeat (2) @(posedge clk);
        `CHK("request after clear", 1'b0, irq)
        bus(1, `PIB_OFS_CONTROL, 32'h0000_0040);
        @(posedge clk);
        fire <= 4'h8;
        @(posedge clk);
        fire <= 4'h0;
        repeat (3) @(posedge clk);
        `CHK("request global off", 1'b0, irq)
        bus(0, `PIB_OFS_FLAGS, 32'h0000_0000);
        `CHK("flag global off", 32'h0000_0020, rd)
        bus(1, `PIB_OFS_FLAGS, 32'h0000_0033);
        bus(1, `PIB_OFS_ENABLE, 32'h0000_0000);
    endtask : t_event_enabled
    task automatic t_mid_reset();
        bus(1, `PIB_OFS_ENABLE, 32'h0000_0033);
        bus(0, `PIB_OFS_ENABLE, 32'h0000_0000);
        `CHK("enable before reset", 32'h0000_0033, rd)
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        bus(0, `PIB_OFS_ENABLE, 32'h0000_0000);
        `CHK("enable after reset", 32'h0000_0000, rd)
        bus(0, `PIB_OFS_CONTROL, 32'h0000_0000);
        `CHK("control after reset", 32'h0000_0000, rd)
    endtask : t_mid_reset
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // Watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        fail_count++;
        $display("ERROR watchdog expired");
        end_of_test();
    end
    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        fire = 4'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_reserved();
        t_gating();
        t_event_enabled();
        t_mid_reset();
        end_of_test();
    end
endmodule : pib_top_tb
